// ===== verilog/hcr_top.sv
// Purpose: Hardware configuration register, suspend indicator, soft resets.
// Assumes: All non-bus inputs come from logic on clk.
// Notes:   full_soft_reset is the power-on reset; nothing survives it.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "hcr_defs.svh"

module hcr_top #(
  parameter int unsigned TO_LONG_CYC = `HCR_TO_LONG_NS / `HCR_CLK_NS
) (
  input  wire logic        clk,
  input  wire logic        full_soft_reset,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [2:0]  power_state,
  input  wire logic        detach_event,
  input  wire logic        usb_reset,
  input  wire logic        image_present,
  input  wire logic        image_loaded,
  input  wire logic [1:0]  image_suspend_indicator_select,
  input  wire logic        image_suspend_indicator_polarity,
  input  wire logic        image_attach_buf,
  input  wire logic        image_attach_en,
  input  wire logic        image_attach_pol,
  input  wire logic        image_led_enable,
  input  wire logic        eeprom_wait,
  input  wire logic        eeprom_response,
  input  wire logic        eeprom_reload_done,
  output logic             eeprom_timeout_flag,
  output logic             eeprom_reload_req,
  output logic             suspend_indicator_pin,
  output logic             multi_frame_pack,
  output logic             attach_buf,
  output logic             attach_en,
  output logic             attach_pol,
  output logic             led_enable,
  output logic             eeprom_emulation_enable,
  output logic             lite_reset_out,
  output logic             core_reset_out,
  output logic             phy_disconnect
);

  localparam logic [21:0] TO_LONG  = 22'(TO_LONG_CYC - 1);
  localparam logic [21:0] TO_SHORT = 22'(`HCR_TO_SHORT_NS / `HCR_CLK_NS - 1);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic is_hwcfg(input logic [11:0] a);
    is_hwcfg = (a[11:2] == `HCR_OFS_HWCFG >> 2);
  endfunction

  function automatic logic is_aux(input logic [11:0] a);
    is_aux = (a[11:2] == `HCR_OFS_AUX >> 2);
  endfunction

  // Image value, or zero when no EEPROM or OTP image exists
  function automatic logic img(input logic v);
    img = image_present & v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  hcr_pkg::hcr_rst_st_t st_q;
  logic [7:0]  seq_cnt_q;
  logic [1:0]  sel_q;
  logic        spol_q;
  logic        mfp_q;
  logic        ets_q;
  logic        abuf_q;
  logic        aen_q;
  logic        apol_q;
  logic        prot_q;
  logic        eem_q;
  logic        led_q;
  logic        det_q;
  logic [21:0] to_cnt_q;
  logic        to_hit_q;
  logic        to_flag_q;
  logic        pin_q;
  logic        reload_req_q;
  logic [11:0] awaddr_q;
  logic        aw_ok_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_ok_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  logic do_wr;
  logic wr_hw0;
  logic wr_hw1;
  logic wr_aux;
  logic lite_end;
  logic full_end;
  logic rst_evt;
  logic reload;
  logic ind_act;

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign awready = ~aw_ok_q & ~bvalid_q;
  assign wready  = ~w_ok_q & ~bvalid_q;
  assign do_wr   = aw_ok_q & w_ok_q & ~bvalid_q;
  assign wr_hw0  = do_wr & is_hwcfg(awaddr_q) & wstrb_q[0];
  assign wr_hw1  = do_wr & is_hwcfg(awaddr_q) & wstrb_q[1];
  assign wr_aux  = do_wr & is_aux(awaddr_q) & wstrb_q[0];
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = ~rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      aw_ok_q  <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (awvalid && awready) begin
      aw_ok_q  <= 1'b1;
      awaddr_q <= awaddr;
    end else if (do_wr) begin
      aw_ok_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      w_ok_q  <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_ok_q  <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (do_wr) begin
      w_ok_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `HCR_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      if (is_hwcfg(awaddr_q) || is_aux(awaddr_q)) begin
        bresp_q <= `HCR_RESP_OKAY;
      end else begin
        bresp_q <= `HCR_RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `HCR_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `HCR_RESP_OKAY;
      if (is_hwcfg(araddr)) begin
        rdata_q[`HCR_B_EEM]     <= eem_q;
        rdata_q[`HCR_B_PROT]    <= prot_q;
        rdata_q[`HCR_B_ABUF]    <= abuf_q;
        rdata_q[`HCR_B_AEN]     <= aen_q;
        rdata_q[`HCR_B_APOL]    <= apol_q;
        rdata_q[`HCR_B_SSEL_HI:`HCR_B_SSEL_LO] <= sel_q;
        rdata_q[`HCR_B_SPOL]    <= spol_q;
        rdata_q[`HCR_B_MFP]     <= mfp_q;
        rdata_q[`HCR_B_ETS]     <= ets_q;
        rdata_q[`HCR_B_LITE]    <= (st_q == hcr_pkg::HCR_LITE);
        rdata_q[`HCR_B_FULL]    <= (st_q == hcr_pkg::HCR_FULL)
                                 | (st_q == hcr_pkg::HCR_RELOAD);
      end else if (is_aux(araddr)) begin
        rdata_q[`HCR_B_LED]     <= led_q;
        rdata_q[`HCR_B_DET]     <= det_q;
      end else begin
        rresp_q <= `HCR_RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Soft reset sequencer
  // ---------------------------------------------------------------
  assign lite_end = (st_q == hcr_pkg::HCR_LITE) && (seq_cnt_q == 8'h00);
  assign full_end = (st_q == hcr_pkg::HCR_RELOAD) && eeprom_reload_done;
  assign rst_evt  = usb_reset | lite_end | full_end;
  assign reload   = rst_evt | image_loaded;

  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      st_q         <= hcr_pkg::HCR_IDLE;
      seq_cnt_q    <= 8'h00;
      reload_req_q <= 1'b0;
    end else begin
      reload_req_q <= 1'b0;
      case (st_q)
        hcr_pkg::HCR_IDLE: begin
          // Full reset wins if both bits are written at once
          if (wr_hw0 && wdata_q[`HCR_B_FULL]) begin
            st_q      <= hcr_pkg::HCR_FULL;
            seq_cnt_q <= `HCR_FULL_CYC - 8'h01;
          end else if (wr_hw0 && wdata_q[`HCR_B_LITE]) begin
            st_q      <= hcr_pkg::HCR_LITE;
            seq_cnt_q <= `HCR_LITE_CYC - 8'h01;
          end
        end
        hcr_pkg::HCR_LITE: begin
          if (seq_cnt_q == 8'h00) begin
            st_q <= hcr_pkg::HCR_IDLE;
          end else begin
            seq_cnt_q <= seq_cnt_q - 8'h01;
          end
        end
        hcr_pkg::HCR_FULL: begin
          if (seq_cnt_q == 8'h00) begin
            st_q         <= hcr_pkg::HCR_RELOAD;
            reload_req_q <= 1'b1;
          end else begin
            seq_cnt_q <= seq_cnt_q - 8'h01;
          end
        end
        hcr_pkg::HCR_RELOAD: begin
          if (eeprom_reload_done) begin
            st_q <= hcr_pkg::HCR_IDLE;
          end
        end
        default: begin
          st_q <= hcr_pkg::HCR_IDLE;
        end
      endcase
    end
  end

  // Lite reset touches only the core: no PHY, USB or EEPROM action
  assign lite_reset_out    = (st_q == hcr_pkg::HCR_LITE);
  assign core_reset_out    = (st_q == hcr_pkg::HCR_FULL);
  assign phy_disconnect    = (st_q == hcr_pkg::HCR_FULL)
                           | (st_q == hcr_pkg::HCR_RELOAD);
  assign eeprom_reload_req = reload_req_q;

  // ---------------------------------------------------------------
  // Protected fields
  // ---------------------------------------------------------------
  // While protected only power-on clears these; protection blocks image restore
  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      sel_q  <= `HCR_SEL_L2;
      spol_q <= 1'b0;
      abuf_q <= 1'b0;
      aen_q  <= 1'b0;
      apol_q <= 1'b0;
    end else if (reload && !prot_q) begin
      sel_q  <= image_present ? image_suspend_indicator_select : `HCR_SEL_L2;
      spol_q <= img(image_suspend_indicator_polarity);
      abuf_q <= img(image_attach_buf);
      aen_q  <= img(image_attach_en);
      apol_q <= img(image_attach_pol);
    end else begin
      if (wr_hw0) begin
        sel_q  <= wdata_q[`HCR_B_SSEL_HI:`HCR_B_SSEL_LO];
        spol_q <= wdata_q[`HCR_B_SPOL];
      end
      if (wr_hw1) begin
        abuf_q <= wdata_q[`HCR_B_ABUF];
        aen_q  <= wdata_q[`HCR_B_AEN];
        apol_q <= wdata_q[`HCR_B_APOL];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      prot_q <= 1'b0;
      eem_q  <= 1'b0;
    end else if (rst_evt && !prot_q) begin
      prot_q <= 1'b0;
      eem_q  <= 1'b0;
    end else if (wr_hw1) begin
      prot_q <= wdata_q[`HCR_B_PROT];
      eem_q  <= wdata_q[`HCR_B_EEM];
    end
  end

  // ---------------------------------------------------------------
  // Unprotected fields
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (full_soft_reset || rst_evt) begin
      mfp_q <= 1'b0;
      ets_q <= 1'b0;
    end else if (wr_hw0) begin
      mfp_q <= wdata_q[`HCR_B_MFP];
      ets_q <= wdata_q[`HCR_B_ETS];
    end
  end

  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      led_q <= 1'b0;
    end else if (reload) begin
      led_q <= img(image_led_enable);
    end else if (wr_aux) begin
      led_q <= wdata_q[`HCR_B_LED];
    end
  end

  // Event set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      det_q <= 1'b0;
    end else if (detach_event) begin
      det_q <= 1'b1;
    end else if (wr_aux && wdata_q[`HCR_B_DET]) begin
      det_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Suspend indicator
  // ---------------------------------------------------------------
  // No gating by emulation enable or EEPROM presence
  always_comb begin
    ind_act = 1'b0;
    case (hcr_pkg::hcr_pwr_t'(power_state))
      hcr_pkg::HCR_PWR_L2:     ind_act = 1'b1;
      hcr_pkg::HCR_PWR_L1:     ind_act = (sel_q != `HCR_SEL_L2);
      hcr_pkg::HCR_PWR_DETACH: ind_act = (sel_q != `HCR_SEL_L2);
      hcr_pkg::HCR_PWR_L0:     ind_act = sel_q[1];
      hcr_pkg::HCR_PWR_L3:     ind_act = (sel_q == `HCR_SEL_L3);
      default:                 ind_act = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (full_soft_reset) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= spol_q ? ind_act : ~ind_act;
    end
  end

  assign suspend_indicator_pin = pin_q;

  // ---------------------------------------------------------------
  // EEPROM response timeout
  // ---------------------------------------------------------------
  // One flag pulse per wait; counter rearms when the wait ends
  always_ff @(posedge clk) begin
    if (full_soft_reset || !eeprom_wait || eeprom_response) begin
      to_cnt_q  <= 22'h00_0000;
      to_hit_q  <= 1'b0;
      to_flag_q <= 1'b0;
    end else begin
      to_flag_q <= 1'b0;
      if (!to_hit_q) begin
        if (to_cnt_q >= (ets_q ? TO_SHORT : TO_LONG)) begin
          to_hit_q  <= 1'b1;
          to_flag_q <= 1'b1;
        end else begin
          to_cnt_q <= to_cnt_q + 22'h00_0001;
        end
      end
    end
  end

  assign eeprom_timeout_flag     = to_flag_q;
  assign multi_frame_pack        = mfp_q;
  assign attach_buf              = abuf_q;
  assign attach_en               = aen_q;
  assign attach_pol              = apol_q;
  assign led_enable              = led_q;
  assign eeprom_emulation_enable = eem_q;

endmodule

// ===== verilog/hcr_defs.svh
// Purpose: Constants of the hardware configuration register block.
// Assumes: 100 MHz clock, AXI4-Lite register access.
// Notes:   Types live in hcr_pkg.
`ifndef HCR_DEFS_SVH
`define HCR_DEFS_SVH

`define HCR_OFS_HWCFG    12'h000
`define HCR_OFS_AUX      12'h004

`define HCR_B_FULL       0
`define HCR_B_LITE       1
`define HCR_B_ETS        3
`define HCR_B_MFP        4
`define HCR_B_SPOL       5
`define HCR_B_SSEL_LO    6
`define HCR_B_SSEL_HI    7
`define HCR_B_APOL       8
`define HCR_B_AEN        9
`define HCR_B_ABUF       10
`define HCR_B_PROT       12
`define HCR_B_EEM        13
`define HCR_B_LED        0
`define HCR_B_DET        1

`define HCR_SEL_L2       2'h0
`define HCR_SEL_L1       2'h1
`define HCR_SEL_L0       2'h2
`define HCR_SEL_L3       2'h3

`define HCR_RESP_OKAY    2'h0
`define HCR_RESP_SLVERR  2'h2

`define HCR_CLK_NS       10
`define HCR_TO_LONG_NS   30000000
`define HCR_TO_SHORT_NS  1280
`define HCR_LITE_CYC     8'h10
`define HCR_FULL_CYC     8'h20

`endif

// ===== verilog/hcr_pkg.sv
// Purpose: Types of the hardware configuration register block.
// Assumes: Used through hcr_pkg::name only.
// Notes:   Gray codes on every step except idle to full.
package hcr_pkg;

  typedef enum logic [1:0] {
    HCR_IDLE   = 2'h0,
    HCR_LITE   = 2'h1,
    HCR_FULL   = 2'h3,
    HCR_RELOAD = 2'h2
  } hcr_rst_st_t;

  typedef enum logic [2:0] {
    HCR_PWR_ACTIVE = 3'h0,
    HCR_PWR_L0     = 3'h1,
    HCR_PWR_L1     = 3'h2,
    HCR_PWR_L2     = 3'h3,
    HCR_PWR_L3     = 3'h4,
    HCR_PWR_DETACH = 3'h5
  } hcr_pwr_t;

endpackage

// ===== verif/hcr_top_assertions.sv
// Purpose: Port-level checks of the soft reset sequences and timeout flag.
// Assumes: Bound into every hcr_top instance.
// Notes:   Run lengths are the 16 and 32 cycle sequence counts.
`timescale 1ns/10ps
module hcr_top_assertions (
  input wire logic clk,
  input wire logic full_soft_reset,
  input wire logic eeprom_wait,
  input wire logic eeprom_response,
  input wire logic eeprom_reload_done,
  input wire logic eeprom_timeout_flag,
  input wire logic eeprom_reload_req,
  input wire logic lite_reset_out,
  input wire logic core_reset_out,
  input wire logic phy_disconnect
);
  default clocking @(posedge clk); endclocking
  default disable iff (full_soft_reset);
  logic [7:0] lite_n_q;
  logic [7:0] full_n_q;
  // ----------------------------------------
  // Run counters
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (full_soft_reset || !lite_reset_out) lite_n_q <= 8'h00;
    else lite_n_q <= lite_n_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (full_soft_reset || !core_reset_out) full_n_q <= 8'h00;
    else full_n_q <= full_n_q + 8'h01;
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  lite_run_max_a: assert property (lite_reset_out |-> lite_n_q < 8'h10)
    else $error("lite reset runs too long");
  // Guard on full_soft_reset: a sync reset also ends the run early
  lite_run_len_a: assert property ($fell(lite_reset_out) && !$past(full_soft_reset) |-> lite_n_q == 8'h10)
    else $error("lite reset length wrong");
  full_run_len_a: assert property ($fell(core_reset_out) && !$past(full_soft_reset) |-> full_n_q == 8'h20)
    else $error("full reset length wrong");
  lite_spare_a: assert property (lite_reset_out |-> !phy_disconnect && !core_reset_out && !eeprom_reload_req)
    else $error("lite reset touched phy or reload");
  full_phy_a: assert property (core_reset_out || eeprom_reload_req |-> phy_disconnect)
    else $error("phy connected during full reset");
  reload_follow_a: assert property ($fell(core_reset_out) && !$past(full_soft_reset) |-> ##[0:2] eeprom_reload_req)
    else $error("no reload request after full reset");
  reload_pulse_a: assert property (eeprom_reload_req |=> !eeprom_reload_req)
    else $error("reload request longer than one cycle");
  phy_release_a: assert property (eeprom_reload_done && phy_disconnect && !core_reset_out |-> ##[1:2] !phy_disconnect)
    else $error("phy not released after reload");
  timeout_cause_a: assert property (eeprom_timeout_flag |-> $past(eeprom_wait) && !$past(eeprom_response))
    else $error("timeout flag without a wait");
  timeout_pulse_a: assert property (eeprom_timeout_flag |=> !eeprom_timeout_flag)
    else $error("timeout flag longer than one cycle");
endmodule

bind hcr_top hcr_top_assertions hcr_top_assertions_inst (.clk, .full_soft_reset, .eeprom_wait,
  .eeprom_response, .eeprom_reload_done, .eeprom_timeout_flag, .eeprom_reload_req,
  .lite_reset_out, .core_reset_out, .phy_disconnect);

// ===== verif/hcr_top_tb.sv
// Purpose: Register-level test of the configuration register block.
// Assumes: AXI4-Lite master tasks; long timeout shortened to 300 cycles.
// Notes:   Image restores expect 0x5A0 from the image inputs set below.
`timescale 1ns/10ps
`include "hcr_defs.svh"
module hcr_top_tb;
  logic        clk, full_soft_reset, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, detach_event, usb_reset, image_present;
  logic        image_loaded, image_suspend_indicator_polarity, image_attach_buf;
  logic        image_attach_en, image_attach_pol, image_led_enable, eeprom_wait;
  logic        eeprom_response, eeprom_reload_done, eeprom_timeout_flag;
  logic        eeprom_reload_req, suspend_indicator_pin, multi_frame_pack, attach_buf;
  logic        attach_en, attach_pol, led_enable, eeprom_emulation_enable;
  logic        lite_reset_out, core_reset_out, phy_disconnect;
  logic [1:0]  bresp, rresp, image_suspend_indicator_select;
  logic [2:0]  power_state;
  logic [3:0]  wstrb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  int          num_errors, checks_done, n;
  localparam logic [1:0] resp_ok  = `HCR_RESP_OKAY;
  localparam logic [1:0] resp_err = `HCR_RESP_SLVERR;

  hcr_top #(.TO_LONG_CYC(300)) hcr_top_inst (.clk, .full_soft_reset, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .power_state, .detach_event, .usb_reset,
    .image_present, .image_loaded, .image_suspend_indicator_select,
    .image_suspend_indicator_polarity, .image_attach_buf, .image_attach_en,
    .image_attach_pol, .image_led_enable, .eeprom_wait, .eeprom_response,
    .eeprom_reload_done, .eeprom_timeout_flag, .eeprom_reload_req,
    .suspend_indicator_pin, .multi_frame_pack, .attach_buf, .attach_en, .attach_pol,
    .led_enable, .eeprom_emulation_enable, .lite_reset_out, .core_reset_out,
    .phy_disconnect);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    fork
      begin do @(posedge clk); while (!awready); awvalid <= 1'h0; end
      begin do @(posedge clk); while (!wready); wvalid <= 1'h0; end
    join
    while (bvalid !== 1'h1) @(posedge clk);
    bready <= 1'h0;
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, e);
    chk(32'(rresp), 32'(er));
  endtask

  task automatic tmo(input int lo, input int hi);
    @(posedge clk);
    eeprom_wait <= 1'h1;
    n = 0;
    do begin @(posedge clk); n++; end while (eeprom_timeout_flag !== 1'h1 && n < 1000);
    eeprom_wait <= 1'h0;
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask

  task automatic usb_pulse;
    @(posedge clk) usb_reset <= 1'h1;
    @(posedge clk) usb_reset <= 1'h0;
    repeat (2) @(posedge clk);
  endtask

  function automatic logic pin_exp(input int s, input int p, input int ps);
    logic on;
    on = ps == 3 || (s >= 1 && (ps == 2 || ps == 5)) || (s >= 2 && ps == 1) || (s == 3 && ps == 4);
    return p ? on : !on;
  endfunction

  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {full_soft_reset, image_present, image_suspend_indicator_polarity, image_attach_buf} = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready, detach_event, usb_reset} = 7'h00;
    {image_loaded, image_attach_en, eeprom_wait, eeprom_response} = 4'h0;
    {eeprom_reload_done, image_attach_pol, image_led_enable} = 3'h3;
    {awaddr, araddr, wdata, power_state} = '0;
    image_suspend_indicator_select = 2'h2;
    wstrb = 4'h3;
    num_errors = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    full_soft_reset <= 1'h0;
    rd(12'h000, 32'h0000_0000, resp_ok);
    chk(32'(suspend_indicator_pin), 32'h0000_0001);
    @(posedge clk) image_loaded <= 1'h1;
    @(posedge clk) image_loaded <= 1'h0;
    rd(12'h000, 32'h0000_05A0, resp_ok);
    rd(12'h004, 32'h0000_0001, resp_ok);
    chk(32'({attach_buf, attach_en, attach_pol}), 32'h0000_0005);
    image_present <= 1'h0;
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        wr(12'h000, 32'(s * 64 + p * 32), resp_ok);
        chk(32'(lite_reset_out), 32'h0000_0000);
        for (int ps = 0; ps < 6; ps++) begin
          @(posedge clk) power_state <= 3'(ps);
          repeat (3) @(posedge clk);
          chk(32'(suspend_indicator_pin), 32'(pin_exp(s, p, ps)));
        end
      end
    end
    image_present <= 1'h1;
    wr(12'h000, 32'h0000_0018, resp_ok);
    rd(12'h000, 32'h0000_0018, resp_ok);
    chk(32'(multi_frame_pack), 32'h0000_0001);
    tmo(126, 130);
    wr(12'h000, 32'h0000_0000, resp_ok);
    tmo(296, 304);
    wr(12'h008, 32'h0000_0001, resp_err);
    rd(12'h008, 32'h0000_0000, resp_err);
    chk(32'(lite_reset_out), 32'h0000_0000);
    wr(12'h004, 32'h0000_0000, resp_ok);
    wr(12'h000, 32'h0000_00FA, resp_ok);
    rd(12'h000, 32'h0000_00FA, resp_ok);
    chk(32'(phy_disconnect), 32'h0000_0000);
    n = 0;
    while (lite_reset_out !== 1'h0 && n < 100) begin @(posedge clk); n++; end
    rd(12'h000, 32'h0000_05A0, resp_ok);
    chk(32'(led_enable), 32'h0000_0001);
    wr(12'h000, 32'h0000_0001, resp_ok);
    rd(12'h000, 32'h0000_0001, resp_ok);
    chk(32'(core_reset_out), 32'h0000_0001);
    n = 0;
    while (eeprom_reload_req !== 1'h1 && n < 100) begin @(posedge clk); n++; end
    chk(32'(phy_disconnect), 32'h0000_0001);
    @(posedge clk) eeprom_reload_done <= 1'h1;
    @(posedge clk) eeprom_reload_done <= 1'h0;
    repeat (3) @(posedge clk);
    chk(32'(phy_disconnect), 32'h0000_0000);
    rd(12'h000, 32'h0000_05A0, resp_ok);
    wr(12'h000, 32'h0000_10E0, resp_ok);
    usb_pulse;
    rd(12'h000, 32'h0000_10E0, resp_ok);
    wr(12'h000, 32'h0000_00E0, resp_ok);
    usb_pulse;
    rd(12'h000, 32'h0000_05A0, resp_ok);
    @(posedge clk) detach_event <= 1'h1;
    @(posedge clk) detach_event <= 1'h0;
    rd(12'h004, 32'h0000_0003, resp_ok);
    wr(12'h000, 32'h0000_30E0, resp_ok);
    chk(32'(eeprom_emulation_enable), 32'h0000_0001);
    @(posedge clk) full_soft_reset <= 1'h1;
    @(posedge clk) full_soft_reset <= 1'h0;
    rd(12'h000, 32'h0000_0000, resp_ok);
    tally_and_finish;
  end
endmodule
